// ### hdl/hpcs_pkg.sv
// Purpose: Constants and carriers for the host port control and status block.
// Assumes: Core bus is 16 bits wide; host bus is byte wide with 3 address pins.
// Notes:   Every offset, bit position and control-register reset value lives here.
package hpcs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] CORE_CTRL_OFS = 16'hffc4;
    localparam logic [15:0] CORE_STAT_OFS = 16'hffe4;
    localparam logic [2:0]  HOST_CTRL_OFS = 3'h0;
    localparam logic [2:0]  HOST_CVR_OFS  = 3'h1;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CC_RX_IE  = 0;
    localparam int CC_TX_IE  = 1;
    localparam int CC_CMD_IE = 2;
    localparam int CC_FLAG0  = 3;
    localparam int CC_FLAG1  = 4;
    localparam int CS_RXF    = 0;
    localparam int CS_TXE    = 1;
    localparam int CS_CMDP   = 2;
    localparam int CS_FLAG0  = 3;
    localparam int CS_FLAG1  = 4;
    localparam int CS_DMA    = 7;
    localparam int HC_RX_REQUEST_ENABLE   = 0;
    localparam int HC_TX_REQUEST_ENABLE   = 1;
    localparam int HC_FLAG0  = 3;
    localparam int HC_FLAG1  = 4;
    localparam int HC_MODE0  = 5;
    localparam int HC_MODE1  = 6;
    localparam int HC_INIT   = 7;
    localparam int CVR_REQ   = 7;

    // ------------------------------------------------------------------
    // Masks, widths and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CORE_CTRL_MASK  = 8'h1f;
    localparam logic [7:0] HOST_CTRL_MASK  = 8'hfb;
    localparam logic [7:0] CORE_CTRL_RST   = 8'h00;
    localparam logic [7:0] HOST_CTRL_RST   = 8'h00;
    localparam int         CMD_VEC_W       = 5;
    localparam logic [1:0] MODE_INTERRUPT  = 2'b00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } hpcs_core_bus_t;

    typedef struct packed {
        logic       wr;
        logic [2:0] addr;
        logic [7:0] data;
    } hpcs_host_bus_t;

endpackage

// ### hdl/hpcs_top.sv
// Purpose: Control and status logic of a byte-wide parallel host port.
// Assumes: Host pins are asynchronous and held stable around the write strobe.
// Notes:   Data byte registers and the DMA counter live outside this block.
`timescale 1ns/1ps
`default_nettype none

module hpcs_top
    import hpcs_pkg::*;
#(
    parameter int VEC_W = CMD_VEC_W
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // Core register bus
    input  wire hpcs_core_bus_t       core_bus,
    output logic [15:0]               core_rdata,
    // Host pins, asynchronous
    input  wire hpcs_host_bus_t       host_pins,
    output logic [7:0]                host_rdata,
    output logic                      host_request_pin,
    // Data path events, same clock
    input  wire logic                 host_to_core_xfer,
    input  wire logic                 core_to_host_xfer,
    input  wire logic                 core_rx_read,
    input  wire logic                 core_tx_write,
    input  wire logic                 host_rx_full,
    input  wire logic                 host_tx_empty,
    // Core exception side
    input  wire logic                 core_cmd_taken,
    output logic                      core_rx_irq,
    output logic                      core_tx_irq,
    output logic                      core_cmd_irq,
    output logic [VEC_W:0]            core_cmd_addr,
    // Host-side status and init effects
    output logic [1:0]                core_to_host_flags,
    output logic                      init_clear_host_rx,
    output logic                      init_set_host_tx,
    output logic                      dma_cnt_load,
    output logic [1:0]                dma_cnt_value
);

    default clocking hpcs_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    if (VEC_W < 1 || VEC_W > 6) begin : g_bad_vec
        $error("VEC_W must lie between 1 and 6");
    end

    // ------------------------------------------------------------------
    // Host pin synchroniser
    // ------------------------------------------------------------------
    hpcs_host_bus_t host_s1;
    hpcs_host_bus_t host_s2;
    logic           host_wr_d;
    logic           host_wr_evt;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_s1   <= '0;
            host_s2   <= '0;
            host_wr_d <= 1'b0;
        end else begin
            host_s1   <= host_pins;
            host_s2   <= host_s1;
            host_wr_d <= host_s2.wr;
        end
    end

    assign host_wr_evt = host_s2.wr & ~host_wr_d;
    logic host_ctrl_wr;
    logic host_cvr_wr;
    logic core_ctrl_wr;
    logic core_stat_rd;
    logic core_ctrl_rd;
    assign host_ctrl_wr = host_wr_evt && host_s2.addr == HOST_CTRL_OFS;
    assign host_cvr_wr  = host_wr_evt && host_s2.addr == HOST_CVR_OFS;
    assign core_ctrl_wr = core_bus.wr && core_bus.addr == CORE_CTRL_OFS;
    assign core_ctrl_rd = core_bus.rd && core_bus.addr == CORE_CTRL_OFS;
    assign core_stat_rd = core_bus.rd && core_bus.addr == CORE_STAT_OFS;

    // ------------------------------------------------------------------
    // Host-side control register
    // ------------------------------------------------------------------
    logic [7:0] host_ctrl;
    logic [1:0] mode;
    logic       dma_mode;
    assign mode     = {host_ctrl[HC_MODE1], host_ctrl[HC_MODE0]};
    assign dma_mode = mode != MODE_INTERRUPT;

    // Init runs one cycle after it is written and then self-clears.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_ctrl <= HOST_CTRL_RST;
        end else if (host_ctrl_wr) begin
            host_ctrl <= host_s2.data & HOST_CTRL_MASK;
        end else if (host_ctrl[HC_INIT]) begin
            host_ctrl[HC_INIT] <= 1'b0;
        end
    end

    logic init_exec;
    assign init_exec = host_ctrl[HC_INIT] && !host_ctrl_wr;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            init_clear_host_rx <= 1'b0;
            init_set_host_tx   <= 1'b0;
            dma_cnt_load       <= 1'b0;
            dma_cnt_value      <= 2'b00;
        end else begin
            init_clear_host_rx <= init_exec && host_ctrl[HC_RX_REQUEST_ENABLE];
            init_set_host_tx   <= init_exec && host_ctrl[HC_TX_REQUEST_ENABLE];
            dma_cnt_load       <= init_exec;
            dma_cnt_value      <= mode;
        end
    end

    // ------------------------------------------------------------------
    // Command request and vector
    // ------------------------------------------------------------------
    logic                cmd_req;
    logic [VEC_W-1:0]    cmd_vec;
    // A host write lands after a same-cycle exception take, so a fresh
    // request is never lost; a cancel may lose against recognition.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_req <= 1'b0;
            cmd_vec <= '0;
        end else if (host_cvr_wr) begin
            cmd_req <= host_s2.data[CVR_REQ];
            cmd_vec <= host_s2.data[VEC_W-1:0];
        end else if (core_cmd_taken) begin
            cmd_req <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Core-side control register and channel flags
    // ------------------------------------------------------------------
    logic [7:0] core_ctrl;
    logic       rx_full;
    logic       tx_empty;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            core_ctrl <= CORE_CTRL_RST;
        end else if (core_ctrl_wr) begin
            core_ctrl <= core_bus.wdata[7:0] & CORE_CTRL_MASK;
        end
    end

    // Channel flags keep working in DMA mode for the unused direction.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_full <= 1'b0;
        end else if (host_to_core_xfer) begin
            rx_full <= 1'b1;
        end else if (core_rx_read || (init_exec && host_ctrl[HC_TX_REQUEST_ENABLE])) begin
            rx_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_empty <= 1'b1;
        end else if (core_to_host_xfer
                     || (init_exec && host_ctrl[HC_RX_REQUEST_ENABLE])) begin
            tx_empty <= 1'b1;
        end else if (core_tx_write) begin
            tx_empty <= 1'b0;
        end
    end

    assign core_rx_irq  = core_ctrl[CC_RX_IE] && rx_full;
    assign core_tx_irq  = core_ctrl[CC_TX_IE] && tx_empty;
    assign core_cmd_irq = core_ctrl[CC_CMD_IE] && cmd_req;
    assign core_to_host_flags = {core_ctrl[CC_FLAG1],
                                 core_ctrl[CC_FLAG0]};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            core_cmd_addr <= '0;
        end else begin
            core_cmd_addr <= {cmd_vec, 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Core and host read ports
    // ------------------------------------------------------------------
    logic [7:0] core_stat;
    always_comb begin
        core_stat           = 8'h00;
        core_stat[CS_RXF]   = rx_full;
        core_stat[CS_TXE]   = tx_empty;
        core_stat[CS_CMDP]  = cmd_req;
        core_stat[CS_FLAG0] = host_ctrl[HC_FLAG0];
        core_stat[CS_FLAG1] = host_ctrl[HC_FLAG1];
        core_stat[CS_DMA]   = dma_mode;
    end

    // Unmapped core reads answer zero.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            core_rdata <= 16'h0000;
        end else if (core_stat_rd) begin
            core_rdata <= {8'h00, core_stat};
        end else if (core_ctrl_rd) begin
            core_rdata <= {8'h00, core_ctrl};
        end else if (core_bus.rd) begin
            core_rdata <= 16'h0000;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_rdata <= 8'h00;
        end else if (host_s2.addr == HOST_CVR_OFS) begin
            host_rdata <= 8'(({7'h00, cmd_req} << CVR_REQ) | 8'(cmd_vec));
        end else begin
            host_rdata <= host_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // Host request pin
    // ------------------------------------------------------------------
    logic rx_cond;
    logic tx_cond;
    logic req_cond;
    assign rx_cond = host_ctrl[HC_RX_REQUEST_ENABLE] && host_rx_full;
    assign tx_cond = host_ctrl[HC_TX_REQUEST_ENABLE] && host_tx_empty;
    // Both enables in DMA mode is illegal; the pin then stays quiet.
    assign req_cond = (rx_cond || tx_cond)
        && !(dma_mode && host_ctrl[HC_RX_REQUEST_ENABLE] && host_ctrl[HC_TX_REQUEST_ENABLE]);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_request_pin <= 1'b0;
        end else begin
            host_request_pin <= req_cond;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_cmd_taken;
        core_cmd_taken && !host_cvr_wr |=> !cmd_req && !core_cmd_irq;
    endproperty
    a_cmd_taken: assert property (p_cmd_taken)
        else $error("command request not cleared on exception");
    property p_cmd_set;
        host_cvr_wr && host_s2.data[CVR_REQ] |=> core_stat[CS_CMDP];
    endproperty
    a_cmd_set: assert property (p_cmd_set)
        else $error("pending not set by host request");
    property p_rx_irq;
        core_rx_irq == (core_ctrl[CC_RX_IE] && core_stat[CS_RXF]);
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("receive interrupt mismatch");
    property p_tx_irq;
        !core_ctrl[CC_TX_IE] |-> !core_tx_irq;
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("transmit interrupt while disabled");
    property p_flags;
        core_ctrl_wr |=> core_to_host_flags == $past(core_bus.wdata[4:3]);
    endproperty
    a_flags: assert property (p_flags)
        else $error("core-to-host flags not written");
    property p_stat_read;
        core_stat_rd |=> core_rdata[15:8] == 8'h00 && core_rdata[6:5] == 2'b00
            && core_rdata[7] == $past(|mode);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status read has bad reserved or mode bits");
    property p_rx_set;
        host_to_core_xfer |=> rx_full ##0 (core_rx_irq == core_ctrl[CC_RX_IE]);
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("receive-full not set by transfer");
    property p_tx_clr;
        core_tx_write && !core_to_host_xfer && !init_exec |=> !tx_empty;
    endproperty
    a_tx_clr: assert property (p_tx_clr)
        else $error("transmit-empty not cleared by core write");
    property p_init_clear;
        init_exec |=> !host_ctrl[HC_INIT] && dma_cnt_load;
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("init did not execute and self-clear");
    property p_req_drop;
        !rx_cond && !tx_cond |=> !host_request_pin;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("request pin held without cause");
    property p_req_irq;
        !dma_mode && (rx_cond || tx_cond) |=> host_request_pin;
    endproperty
    a_req_irq: assert property (p_req_irq)
        else $error("request pin missing in interrupt mode");

endmodule

`default_nettype wire

// ### tb/hpcs_host_model.sv
// Purpose: Host processor model driving the byte-wide host pins.
// Assumes: Each strobe phase lasts four cycles, above the sync need.
// Notes:   Released data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none

module hpcs_host_model
    import hpcs_pkg::*;
(
    // Clock
    input  wire logic          clk_sys,
    // Host pins
    output var hpcs_host_bus_t host_pins,
    input  wire logic [7:0]    host_rdata
);
    initial begin
        host_pins = '0;
    end

    // Request bit and vector travel together in one write cycle.
    task automatic write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        host_pins <= '{wr: 1'b1, addr: a, data: d};
        repeat (4) @(posedge clk_sys);
        host_pins <= '{wr: 1'b0, addr: a, data: ~d};
        repeat (4) @(posedge clk_sys);
    endtask

    // The read path is synchronised, so the address settles before sampling.
    task automatic read(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        host_pins.addr <= a;
        repeat (5) @(posedge clk_sys);
        #1 d = host_rdata;
    endtask
endmodule

`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the host port control and status block.
// Assumes: Host model holds each strobe phase four cycles.
// Notes:   Expected values come from an integer model kept here.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import hpcs_pkg::*;
;
    logic               clk_sys, rst, host_rx_full, host_tx_empty;
    hpcs_core_bus_t     core_bus;
    hpcs_host_bus_t     host_pins;
    logic [15:0]        core_rdata, rd16;
    logic [7:0]         host_rdata, hd;
    logic [4:0]         ev, vec;
    logic               host_request_pin, core_rx_irq, core_tx_irq;
    logic               core_cmd_irq, init_clear_host_rx, init_set_host_tx;
    logic               dma_cnt_load;
    logic [CMD_VEC_W:0] core_cmd_addr;
    logic [1:0]         core_to_host_flags, dma_cnt_value, last_val;
    int                 miscompares, checks_done, m_ctrl, m_hc, m_cmdp;
    int                 m_rxf, m_txe, n_load, n_clr, n_set, r, en, lv, exp;
    int                 cfg[7] = '{0, 1, 2, 3, 'h41, 'h42, 'h43};

    hpcs_top #(.VEC_W(CMD_VEC_W)) hpcs_top_inst (
        .clk_sys(clk_sys), .rst(rst), .core_bus(core_bus),
        .core_rdata(core_rdata), .host_pins(host_pins),
        .host_rdata(host_rdata), .host_request_pin(host_request_pin),
        .host_to_core_xfer(ev[0]), .core_to_host_xfer(ev[1]),
        .core_rx_read(ev[2]), .core_tx_write(ev[3]),
        .host_rx_full(host_rx_full), .host_tx_empty(host_tx_empty),
        .core_cmd_taken(ev[4]), .core_rx_irq(core_rx_irq),
        .core_tx_irq(core_tx_irq), .core_cmd_irq(core_cmd_irq),
        .core_cmd_addr(core_cmd_addr),
        .core_to_host_flags(core_to_host_flags),
        .init_clear_host_rx(init_clear_host_rx),
        .init_set_host_tx(init_set_host_tx), .dma_cnt_load(dma_cnt_load),
        .dma_cnt_value(dma_cnt_value));

    hpcs_host_model hpcs_host_model_inst (
        .clk_sys(clk_sys), .host_pins(host_pins), .host_rdata(host_rdata));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cwr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        core_bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_sys);
        core_bus.wr <= 1'b0;
    endtask

    task automatic crd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        core_bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge clk_sys);
        core_bus.rd <= 1'b0;
        #1 d = core_rdata;
    endtask

    task automatic hrd(input logic [2:0] a, input logic [7:0] want);
        hpcs_host_model_inst.read(a, hd);
        check({8'h00, hd}, {8'h00, want});
    endtask

    task automatic pulse(input int i);
        @(posedge clk_sys);
        ev[i] <= 1'b1;
        @(posedge clk_sys);
        ev[i] <= 1'b0;
    endtask

    // Status word, core interrupt outputs and core-to-host flags as the model predicts them.
    task automatic vfy();
        crd(CORE_STAT_OFS, rd16);
        check(rd16, 16'(((m_hc & 'h60) != 0 ? 'h80 : 0) | (m_hc & 'h18)
              | (m_cmdp << 2) | (m_txe << 1) | m_rxf));
        check({11'h000, core_rx_irq, core_tx_irq, core_cmd_irq,
               core_to_host_flags}, 16'(((m_ctrl & m_rxf) << 4)
              | ((m_ctrl >> 1 & m_txe) << 3) | ((m_ctrl >> 2 & m_cmdp) << 2)
              | (m_ctrl >> 3 & 3)));
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        m_ctrl = 0;
        m_hc = 0;
        m_cmdp = 0;
        m_rxf = 0;
        m_txe = 1;
        repeat (3) @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        if (dma_cnt_load === 1'b1) begin
            n_load++;
            last_val = dma_cnt_value;
        end
        if (init_clear_host_rx === 1'b1) n_clr++;
        if (init_set_host_tx === 1'b1) n_set++;
    end

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        miscompares++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        core_bus = '0;
        ev = '0;
        host_rx_full = 1'b0;
        host_tx_empty = 1'b0;
        rst = 1'b1;
        r = $urandom(32'he50c5a22);
        do_reset();
        vfy();
        crd(CORE_CTRL_OFS, rd16);
        check(rd16, 16'h0000);
        crd(16'hffc6, rd16);
        check(rd16, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            r = $urandom();
            cwr(CORE_CTRL_OFS, 16'((r & 'hffe0) | (i << 3) | 7));
            m_ctrl = (i << 3) | 7;
            crd(CORE_CTRL_OFS, rd16);
            check(rd16, 16'(m_ctrl));
            vfy();
        end
        cwr(CORE_STAT_OFS, 16'hffff);
        vfy();
        pulse(0);
        m_rxf = 1;
        vfy();
        cwr(CORE_CTRL_OFS, 16'h0018);
        m_ctrl = 'h18;
        vfy();
        cwr(CORE_CTRL_OFS, 16'h0007);
        m_ctrl = 7;
        pulse(2);
        m_rxf = 0;
        vfy();
        pulse(3);
        m_txe = 0;
        vfy();
        pulse(1);
        m_txe = 1;
        vfy();
        vec = 5'($urandom());
        hpcs_host_model_inst.write(HOST_CVR_OFS, {3'b100, vec});
        m_cmdp = 1;
        vfy();
        check(16'(core_cmd_addr), 16'({vec, 1'b0}));
        hrd(HOST_CVR_OFS, {3'b100, vec});
        pulse(4);
        m_cmdp = 0;
        vfy();
        hrd(HOST_CVR_OFS, {3'b000, vec});
        cwr(CORE_CTRL_OFS, 16'h0003);
        m_ctrl = 3;
        hpcs_host_model_inst.write(HOST_CVR_OFS, 8'h80);
        m_cmdp = 1;
        vfy();
        hpcs_host_model_inst.write(HOST_CVR_OFS, 8'h00);
        m_cmdp = 0;
        vfy();
        for (int m = 0; m < 4; m++) begin
            m_hc = (m << 5) | (($urandom() & 3) << 3);
            hpcs_host_model_inst.write(HOST_CTRL_OFS, 8'(m_hc | 4));
            hrd(HOST_CTRL_OFS, 8'(m_hc));
            pulse(0);
            m_rxf = 1;
            vfy();
            pulse(2);
            m_rxf = 0;
            vfy();
        end
        foreach (cfg[k]) begin
            hpcs_host_model_inst.write(HOST_CTRL_OFS, 8'(cfg[k]));
            m_hc = cfg[k];
            en = cfg[k] & 3;
            for (lv = 0; lv < 4; lv++) begin
                @(posedge clk_sys);
                host_rx_full <= lv[0];
                host_tx_empty <= lv[1];
                @(posedge clk_sys);
                #1;
                exp = (cfg[k] > 3 && en == 3) ? 0 : ((en & lv) != 0);
                check(16'(host_request_pin), 16'(exp));
            end
        end
        @(posedge clk_sys);
        host_rx_full <= 1'b0;
        host_tx_empty <= 1'b0;
        pulse(0);
        m_rxf = 1;
        pulse(3);
        m_txe = 0;
        hpcs_host_model_inst.write(HOST_CTRL_OFS, 8'h03);
        m_hc = 3;
        n_load = 0;
        n_clr = 0;
        n_set = 0;
        hpcs_host_model_inst.write(HOST_CTRL_OFS, 8'h83);
        m_rxf = 0;
        m_txe = 1;
        check(16'({n_load[3:0], n_clr[3:0], n_set[3:0], 2'b00, last_val}),
              16'h1110);
        hrd(HOST_CTRL_OFS, 8'h03);
        vfy();
        pulse(3);
        m_txe = 0;
        hpcs_host_model_inst.write(HOST_CTRL_OFS, 8'h41);
        hpcs_host_model_inst.write(HOST_CTRL_OFS, 8'hc1);
        m_hc = 'h41;
        m_txe = 1;
        check(16'({n_load[3:0], n_clr[3:0], n_set[3:0], 2'b00, last_val}),
              16'h2212);
        vfy();
        hpcs_host_model_inst.write(HOST_CTRL_OFS, 8'h79);
        hpcs_host_model_inst.write(HOST_CVR_OFS, 8'h80);
        do_reset();
        hrd(HOST_CTRL_OFS, 8'h00);
        vfy();
        complete_run();
    end
endmodule

`default_nettype wire
